//--- hw/pwm_pkg.sv
// Contract
// - Disable bit zero gives pin to timer
// - Bits 7:4 channel 1, 3:0 channel 0
// - Three-bit field picks counting clock source
// - Bit 0 gates match A interrupt
// - Bits 1-3 gate match B, C, D
// - Bit 4 gates overflow/underflow interrupt
// - Two identical enable registers, independent channels
// - Pin C initial level bit at 2
// - Sixteen-bit counter counts up and down
// - Overflow sets channel 0 overflow flag
// - Level select bit picks active level
package pwm_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFS_PIN_DISABLE = 8'h00; // pin_output_disable
    localparam logic [7:0] OFS_CH0_CTRL    = 8'h04; // channel0_control
    localparam logic [7:0] OFS_CH0_IRQ_EN  = 8'h08; // channel0_irq_enable
    localparam logic [7:0] OFS_CH1_IRQ_EN  = 8'h0C; // channel1_irq_enable
    localparam logic [7:0] OFS_INIT_LEVEL  = 8'h10; // initial_output_level
    localparam logic [7:0] OFS_CH0_COUNTER = 8'h14; // channel0_counter
    localparam logic [7:0] OFS_START       = 8'h18; // start_control
    localparam logic [7:0] OFS_CH0_STATUS  = 8'h1C; // channel0_status, write one to clear
    localparam logic [7:0] OFS_CH1_STATUS  = 8'h20; // channel1_status, write one to clear
    localparam logic [7:0] OFS_LEVEL_SEL   = 8'h24; // phase level selects
    localparam logic [7:0] OFS_PERIOD      = 8'h28; // turnaround value
    localparam logic [7:0] OFS_DUTY        = 8'h2C; // change point

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CH0_PIN_A      = 0; // Channel 0 pin A disable
    localparam int CH0_PIN_C      = 2; // Channel 0 pin C (half-period pin)
    localparam int IRQ_WRAP_BIT   = 4; // Overflow/underflow enable
    localparam int INIT_C0_BIT    = 2; // Pin C initial level
    localparam int RUN0_BIT       = 0; // ch0_run
    localparam int RUN1_BIT       = 1; // ch1_run
    localparam int NORM_LSEL_BIT  = 0; // normal_phase_level_sel
    localparam int CNTR_LSEL_BIT  = 1; // counter_phase_level_sel

    // ****************************************************************
    // Reset values and encodings
    // ****************************************************************
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [15:0] RST_WORD    = 16'h0000;
    localparam logic [15:0] RST_PERIOD  = 16'hFFFF;
    localparam logic [2:0]  SRC_CLK     = 3'h0; // System clock
    localparam logic [2:0]  SRC_DIV2    = 3'h1;
    localparam logic [2:0]  SRC_DIV4    = 3'h2;
    localparam logic [2:0]  SRC_DIV8    = 3'h3;
    localparam logic [2:0]  SRC_DIV32   = 3'h4;
    localparam logic [2:0]  SRC_EXT     = 3'h5; // external_count_clock_pin
    localparam int          PRE_WIDTH   = 5;    // Prescaler reaches divide by 32

    // Counter direction states
    typedef enum logic [2:0]
    {
        CNT_IDLE = 3'b001,
        CNT_UP   = 3'b010,
        CNT_DOWN = 3'b100
    } cnt_state_t;

    // Per-channel event flags, laid out as the status register
    typedef struct packed
    {
        logic underflow_flag; // bit 5
        logic overflow_flag;  // bit 4
        logic match_d_flag;   // bit 3
        logic match_c_flag;   // bit 2
        logic match_b_flag;   // bit 1
        logic match_a_flag;   // bit 0
    } flags_t;

    // Decoded APB write strobe with its data
    typedef struct packed
    {
        logic        en;
        logic [7:0]  addr;
        logic [31:0] data;
    } wr_t;

endpackage

//--- hw/pwm_top.sv
`timescale 1ns/1ps
module pwm_top
(
    input  wire logic        SYS_CLK,          // 100 MHz clock
    input  wire logic        NRST,             // Asynchronous reset, active low
    input  wire logic        PSEL,             // APB select
    input  wire logic        PENABLE,          // APB access phase
    input  wire logic        PWRITE,           // APB direction
    input  wire logic [7:0]  PADDR,            // APB byte address
    input  wire logic [31:0] PWDATA,           // APB write data
    output logic      [31:0] PRDATA,           // APB read data
    output logic             PREADY,           // APB ready
    output logic             PSLVERR,          // APB error on unmapped address
    input  wire logic        EXT_COUNT_CLK,    // external_count_clock_pin
    output logic      [7:0]  PIN_OUT,          // Timer level for each pin
    output logic      [7:0]  PIN_TMR_EN,       // High while the timer owns the pin
    output logic             IRQ               // Level interrupt
);

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic       rst_meta_q;                    // First synchroniser stage
    logic       rst_n_q;                       // Released reset copy

    // Asserts at once, releases two edges later to avoid a ragged release
    always_ff @(posedge SYS_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [7:0]            odis_q;             // pin_output_disable
    logic [7:0]            ctrl_q;             // channel0_control
    logic [7:0]            ien0_q;             // channel0_irq_enable
    logic [7:0]            ien1_q;             // channel1_irq_enable
    logic [7:0]            init_q;             // initial_output_level
    logic [1:0]            start_q;            // start_control
    logic [1:0]            lsel_q;             // Phase level selects
    logic [15:0]           period_q;           // Turnaround value
    logic [15:0]           duty_q;             // Change point
    logic [15:0]           dead_q;             // Last dead time loaded
    logic [15:0]           cnt_q;              // channel0_counter
    pwm_pkg::flags_t       st0_q;              // channel0_status
    pwm_pkg::flags_t       st1_q;              // channel1_status
    pwm_pkg::flags_t       ev0;                // Channel 0 events this cycle
    pwm_pkg::flags_t       ev1;                // Channel 1 events this cycle
    pwm_pkg::cnt_state_t   state_q;            // Counter direction
    pwm_pkg::wr_t          wr;                 // Write strobe
    logic                  running;            // Both channels started
    logic                  tick;               // Count source edge

    // ****************************************************************
    // APB slave
    // ****************************************************************
    // Zero wait states: the answer is in the first access cycle
    assign PREADY   = 1'b1;
    assign wr.en    = PSEL && PENABLE && PWRITE;
    assign wr.addr  = PADDR;
    assign wr.data  = PWDATA;

    logic          mapped;                     // Address hits a register
    logic [31:0]   rd_mux;                     // Read data before the flop

    // Decode the address and choose read data
    always_comb
    begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (PADDR)
            pwm_pkg::OFS_PIN_DISABLE: rd_mux = {24'h000000, odis_q};
            pwm_pkg::OFS_CH0_CTRL:    rd_mux = {24'h000000, ctrl_q};
            pwm_pkg::OFS_CH0_IRQ_EN:  rd_mux = {24'h000000, ien0_q};
            pwm_pkg::OFS_CH1_IRQ_EN:  rd_mux = {24'h000000, ien1_q};
            pwm_pkg::OFS_INIT_LEVEL:  rd_mux = {24'h000000, init_q};
            pwm_pkg::OFS_CH0_COUNTER: rd_mux = {16'h0000, cnt_q};
            pwm_pkg::OFS_START:       rd_mux = {30'h0, start_q};
            pwm_pkg::OFS_CH0_STATUS:  rd_mux = {26'h0, st0_q};
            pwm_pkg::OFS_CH1_STATUS:  rd_mux = {26'h0, st1_q};
            pwm_pkg::OFS_LEVEL_SEL:   rd_mux = {30'h0, lsel_q};
            pwm_pkg::OFS_PERIOD:      rd_mux = {16'h0000, period_q};
            pwm_pkg::OFS_DUTY:        rd_mux = {16'h0000, duty_q};
            default:                  mapped = 1'b0; // Unmapped reads zero and errors
        endcase
    end

    // Read data is captured in the setup cycle so it comes from a flop
    always_ff @(posedge SYS_CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else if (PSEL && !PENABLE)
        begin
            PRDATA  <= PWRITE ? 32'h0000_0000 : rd_mux;
            PSLVERR <= !mapped;
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    // Plain read/write registers; unused enable bits 7:5 stay zero
    always_ff @(posedge SYS_CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            odis_q  <= pwm_pkg::RST_BYTE;
            ctrl_q  <= pwm_pkg::RST_BYTE;
            ien0_q  <= pwm_pkg::RST_BYTE;
            ien1_q  <= pwm_pkg::RST_BYTE;
            init_q  <= pwm_pkg::RST_BYTE;
            start_q <= 2'h0;
            lsel_q  <= 2'h0;
        end
        else if (wr.en)
        begin
            case (wr.addr)
                pwm_pkg::OFS_PIN_DISABLE: odis_q  <= wr.data[7:0];
                pwm_pkg::OFS_CH0_CTRL:    ctrl_q  <= wr.data[7:0];
                pwm_pkg::OFS_CH0_IRQ_EN:  ien0_q  <= {3'h0, wr.data[4:0]};
                pwm_pkg::OFS_CH1_IRQ_EN:  ien1_q  <= {3'h0, wr.data[4:0]};
                pwm_pkg::OFS_INIT_LEVEL:  init_q  <= wr.data[7:0];
                pwm_pkg::OFS_START:       start_q <= wr.data[1:0];
                pwm_pkg::OFS_LEVEL_SEL:   lsel_q  <= wr.data[1:0];
                default:                  ;                                     // Others elsewhere
            endcase
        end
    end

    // Period and duty are frozen while both channels run
    always_ff @(posedge SYS_CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            period_q <= pwm_pkg::RST_PERIOD;
            duty_q   <= pwm_pkg::RST_WORD;
        end
        else if (wr.en && !running)
        begin
            // Writes during a run are dropped to avoid a torn cycle
            if (wr.addr == pwm_pkg::OFS_PERIOD)
                period_q <= wr.data[15:0];
            if (wr.addr == pwm_pkg::OFS_DUTY)
                duty_q <= wr.data[15:0];
        end
    end

    assign running = start_q[pwm_pkg::RUN0_BIT] && start_q[pwm_pkg::RUN1_BIT];

    // ****************************************************************
    // Count source
    // ****************************************************************
    logic [pwm_pkg::PRE_WIDTH-1:0] pre_q;      // Free-running prescaler
    logic                          ext_q;      // Last external clock level

    // Prescaler and external edge detect
    always_ff @(posedge SYS_CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            pre_q <= '0;
            ext_q <= 1'b0;
        end
        else
        begin
            pre_q <= pre_q + 1'b1;
            ext_q <= EXT_COUNT_CLK;
        end
    end

    // One tick per source period; the two unused codes never count
    always_comb
    begin
        case (ctrl_q[2:0])
            pwm_pkg::SRC_CLK:   tick = 1'b1;
            pwm_pkg::SRC_DIV2:  tick = &pre_q[0:0];
            pwm_pkg::SRC_DIV4:  tick = &pre_q[1:0];
            pwm_pkg::SRC_DIV8:  tick = &pre_q[2:0];
            pwm_pkg::SRC_DIV32: tick = &pre_q[4:0];
            pwm_pkg::SRC_EXT:   tick = EXT_COUNT_CLK && !ext_q;
            default:            tick = 1'b0;
        endcase
    end

    // ****************************************************************
    // Up/down counter
    // ****************************************************************
    logic cnt_wr;                              // Software loads the counter
    logic at_top;                              // Up count reaches period
    logic at_bottom;                           // Down count reaches zero
    assign cnt_wr    = wr.en && (wr.addr == pwm_pkg::OFS_CH0_COUNTER);
    assign at_top    = (state_q == pwm_pkg::CNT_UP) && (cnt_q == period_q);
    assign at_bottom = (state_q == pwm_pkg::CNT_DOWN) && (cnt_q == 16'h0000);

    // A software load wins over a tick in the same cycle
    always_ff @(posedge SYS_CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            cnt_q   <= pwm_pkg::RST_WORD;
            dead_q  <= pwm_pkg::RST_WORD;
            state_q <= pwm_pkg::CNT_IDLE;
        end
        else if (cnt_wr)
        begin
            cnt_q  <= wr.data[15:0];
            dead_q <= wr.data[15:0];
        end
        else if (!running)
            state_q <= pwm_pkg::CNT_IDLE;
        else if (tick)
        begin
            case (state_q)
                pwm_pkg::CNT_IDLE:
                begin
                    state_q <= pwm_pkg::CNT_UP;
                    cnt_q   <= cnt_q + 16'h0001;
                end
                pwm_pkg::CNT_UP:
                begin
                    state_q <= at_top ? pwm_pkg::CNT_DOWN : pwm_pkg::CNT_UP;
                    cnt_q   <= at_top ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
                end
                pwm_pkg::CNT_DOWN:
                begin
                    state_q <= at_bottom ? pwm_pkg::CNT_UP : pwm_pkg::CNT_DOWN;
                    cnt_q   <= at_bottom ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
                end
                default:
                    state_q <= pwm_pkg::CNT_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // Events, status and interrupt
    // ****************************************************************
    logic live;                                // Counting tick without a load
    assign live = running && tick && !cnt_wr;

    // Events of this tick, in status layout
    always_comb
    begin
        ev0                = '0;
        ev1                = '0;
        ev0.match_a_flag   = live && at_top;
        ev0.match_b_flag   = live && (state_q == pwm_pkg::CNT_UP) && (cnt_q == duty_q);
        ev0.match_c_flag   = live && (state_q == pwm_pkg::CNT_DOWN) && (cnt_q == duty_q);
        ev0.match_d_flag   = live && (state_q == pwm_pkg::CNT_DOWN) && (cnt_q == dead_q);
        ev0.overflow_flag  = live && at_top;
        ev1.underflow_flag = live && at_bottom;
    end

    // Sticky flags; a set in the clearing cycle wins
    always_ff @(posedge SYS_CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            st0_q <= '0;
            st1_q <= '0;
        end
        else
        begin
            st0_q <= ev0 | (st0_q & ~((wr.en && wr.addr == pwm_pkg::OFS_CH0_STATUS) ? wr.data[5:0] : 6'h00));
            st1_q <= ev1 | (st1_q & ~((wr.en && wr.addr == pwm_pkg::OFS_CH1_STATUS) ? wr.data[5:0] : 6'h00));
        end
    end

    logic [1:0] req;                           // Per-channel request
    logic       ch_wrap0;                      // Channel 0 wrap source
    logic       ch_wrap1;                      // Channel 1 wrap source
    assign ch_wrap0 = st0_q.overflow_flag | st0_q.underflow_flag;
    assign ch_wrap1 = st1_q.overflow_flag | st1_q.underflow_flag;
    // Enables mask the request only; flags stay as they are
    assign req[0] = |(st0_q[3:0] & ien0_q[3:0])
                  | (ch_wrap0 & ien0_q[pwm_pkg::IRQ_WRAP_BIT]);
    assign req[1] = |(st1_q[3:0] & ien1_q[3:0])
                  | (ch_wrap1 & ien1_q[pwm_pkg::IRQ_WRAP_BIT]);
    assign IRQ = |req;

    // ****************************************************************
    // Pin outputs
    // ****************************************************************
    logic norm_act;                            // Normal-phase active level
    logic cntr_act;                            // Counter-phase active level
    logic pwm_on;                              // Normal phase is active
    logic half_q;                              // Half-period pin level
    logic cntr_on;                             // Counter phase is active
    assign norm_act = lsel_q[pwm_pkg::NORM_LSEL_BIT];
    assign cntr_act = lsel_q[pwm_pkg::CNTR_LSEL_BIT];
    assign pwm_on   = (state_q != pwm_pkg::CNT_IDLE) && (cnt_q < duty_q);
    // Idle shows the initial, inactive level on the counter phase as well
    assign cntr_on  = (state_q != pwm_pkg::CNT_IDLE) && !(cnt_q < duty_q);

    // Pin C starts at its chosen level and inverts at each turnaround
    always_ff @(posedge SYS_CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
            half_q <= 1'b1;
        else if (state_q == pwm_pkg::CNT_IDLE)
            half_q <= init_q[pwm_pkg::INIT_C0_BIT] ? norm_act : !norm_act;
        else if (live && (at_top || at_bottom))
            half_q <= !half_q;
    end

    // Pin levels come from flops; ownership follows the disable bits
    always_ff @(posedge SYS_CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
            PIN_OUT <= 8'hFF;
        else
        begin
            PIN_OUT[0] <= !norm_act;
            PIN_OUT[1] <= pwm_on ? norm_act : !norm_act;
            PIN_OUT[2] <= half_q;
            PIN_OUT[3] <= cntr_on ? cntr_act : !cntr_act;
            PIN_OUT[4] <= pwm_on ? norm_act : !norm_act;
            PIN_OUT[5] <= pwm_on ? norm_act : !norm_act;
            PIN_OUT[6] <= cntr_on ? cntr_act : !cntr_act;
            PIN_OUT[7] <= cntr_on ? cntr_act : !cntr_act;
        end
    end

    assign PIN_TMR_EN = ~odis_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!rst_n_q);

    property p_odis_write;
        wr.en && wr.addr == pwm_pkg::OFS_PIN_DISABLE |=> PIN_TMR_EN == ~$past(PWDATA[7:0]);
    endproperty
    a_odis_write: assert property (p_odis_write) else $error("pin ownership wrong");

    property p_pin_a_bit;
        odis_q[pwm_pkg::CH0_PIN_A] |-> !PIN_TMR_EN[0] ##1 (odis_q[7:4] == ~PIN_TMR_EN[7:4]);
    endproperty
    a_pin_a_bit: assert property (p_pin_a_bit) else $error("pin bit order wrong");

    property p_div2;
        ctrl_q[2:0] == pwm_pkg::SRC_DIV2 && tick && !wr.en ##1 !wr.en |-> !tick ##1 tick;
    endproperty
    a_div2: assert property (p_div2) else $error("divide by two wrong");

    property p_match_irq;
        (st0_q[0] && ien0_q[0]) || (st0_q[3] && ien0_q[3]) |-> IRQ;
    endproperty
    a_match_irq: assert property (p_match_irq) else $error("match request missing");

    property p_wrap_irq;
        st0_q.overflow_flag && ien0_q[pwm_pkg::IRQ_WRAP_BIT] |-> IRQ;
    endproperty
    a_wrap_irq: assert property (p_wrap_irq) else $error("wrap request missing");

    property p_quiet;
        !req[0] && ien1_q == 8'h00 |-> !IRQ;
    endproperty
    a_quiet: assert property (p_quiet) else $error("channel 1 leaks");

    property p_init_level;
        state_q == pwm_pkg::CNT_IDLE ##1 state_q == pwm_pkg::CNT_IDLE ##1 state_q == pwm_pkg::CNT_IDLE
            |-> PIN_OUT[2] == $past(init_q[2] ~^ norm_act, 2);
    endproperty
    a_init_level: assert property (p_init_level) else $error("pin C initial level wrong");

    property p_count_up;
        live && state_q == pwm_pkg::CNT_UP && !at_top |=> cnt_q == $past(cnt_q) + 16'h0001;
    endproperty
    a_count_up: assert property (p_count_up) else $error("up count wrong");

    property p_overflow;
        live && at_top |=> st0_q.overflow_flag && state_q == pwm_pkg::CNT_DOWN;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow flag missing");

    property p_irq_cause;
        IRQ |-> (|(st0_q[3:0] & ien0_q[3:0])) || (ch_wrap0 && ien0_q[4]) || req[1];
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("request without cause");

    c_overflow:  cover property (live && at_top);
    c_underflow: cover property (live && at_bottom);
    c_irq_rise:  cover property (!IRQ ##1 IRQ);

endmodule

//--- sim/complementary_pwm_output_setup_test.sv
`timescale 1ns/1ps
// ****************************************************************
// Bench
// ****************************************************************
module complementary_pwm_output_setup_test;
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr, irq, ext_clk, err;
    logic [7:0]  paddr, pin_out, pin_tmr_en, pin_level;
    logic [31:0] pwdata, prdata, rd;
    int          failures = 0;
    int          n_tests = 0;
    int          k;
    // Rows: offset, written value, value read back
    logic [7:0]  rows [6][3] = '{'{pwm_pkg::OFS_PIN_DISABLE, 8'h01, 8'h01},
        '{pwm_pkg::OFS_CH0_IRQ_EN, 8'hFF, 8'h1F}, '{pwm_pkg::OFS_CH1_IRQ_EN, 8'hFF, 8'h1F},
        '{pwm_pkg::OFS_INIT_LEVEL, 8'h04, 8'h04}, '{pwm_pkg::OFS_CH0_CTRL, 8'h01, 8'h01},
        '{pwm_pkg::OFS_LEVEL_SEL, 8'h03, 8'h03}};

    pwm_top dut (.SYS_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .EXT_COUNT_CLK(ext_clk), .PIN_OUT(pin_out), .PIN_TMR_EN(pin_tmr_en), .IRQ(irq));
    power_stage load (.clk(clk), .pin_out(pin_out), .pin_tmr_en(pin_tmr_en), .ext_clk(ext_clk),
        .pin_level(pin_level));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    initial
    begin
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (20) @(posedge clk);
        chk(pin_tmr_en, 8'hFF);
        chk(pin_level, 8'hFF);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (rows[i])
        begin
            apb(1'b1, rows[i][0], {24'h0, rows[i][1]});
            apb(1'b0, rows[i][0], 32'h0);
            chk(rd, {24'h0, rows[i][2]});
        end
        chk(pin_tmr_en, 8'hFE);
        chk(pin_level, 8'h04);
        apb(1'b0, 8'h3C, 32'h0);
        chk(err, 1'b1);
        // Count from the dead time up to the turnaround
        apb(1'b1, pwm_pkg::OFS_CH0_CTRL, 32'h0);
        apb(1'b1, pwm_pkg::OFS_CH0_IRQ_EN, 32'h10);
        apb(1'b1, pwm_pkg::OFS_CH1_IRQ_EN, 32'h0);
        apb(1'b1, pwm_pkg::OFS_CH0_COUNTER, 32'h2);
        apb(1'b1, pwm_pkg::OFS_PERIOD, 32'h6);
        apb(1'b1, pwm_pkg::OFS_START, 32'h3);
        k = 0;
        while (irq !== 1'b1 && k < 100)
        begin
            @(posedge clk);
            k++;
        end
        chk(irq, 1'b1);
        apb(1'b0, pwm_pkg::OFS_CH0_STATUS, 32'h0);
        chk(rd & 32'h11, 32'h11);
        apb(1'b1, pwm_pkg::OFS_CH0_IRQ_EN, 32'h0);
        #1 chk(irq, 1'b0);
        apb(1'b0, pwm_pkg::OFS_CH0_STATUS, 32'h0);
        chk(rd & 32'h10, 32'h10);
        apb(1'b1, pwm_pkg::OFS_CH0_IRQ_EN, 32'h1);
        #1 chk(irq, 1'b1);
        apb(1'b1, pwm_pkg::OFS_START, 32'h0);
        apb(1'b1, pwm_pkg::OFS_CH0_STATUS, 32'h3F);
        #1 chk(irq, 1'b0);
        // External source: two ticks, eight cycles apart, reach the turnaround
        apb(1'b1, pwm_pkg::OFS_CH0_CTRL, {29'h0, pwm_pkg::SRC_EXT});
        apb(1'b1, pwm_pkg::OFS_CH0_COUNTER, 32'h5);
        apb(1'b1, pwm_pkg::OFS_START, 32'h3);
        k = 0;
        while (irq !== 1'b1 && k < 100)
        begin
            @(posedge clk);
            k++;
        end
        chk((k >= 8) && (k <= 20), 1'b1);
        close_out;
    end

    // Cuts a hang short
    initial
    begin
        #100us;
        failures++;
        close_out;
    end
endmodule

//--- sim/power_stage.sv
`timescale 1ns/1ps
// ****************************************************************
// Power stage model
// ****************************************************************
module power_stage
(
    input  wire logic       clk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_tmr_en,
    output logic            ext_clk,
    output logic [7:0]      pin_level
);
    logic [7:0] drive;       // Level seen by the load
    logic [2:0] div_q = 3'h0; // Slow external count source

    // A pin released by the timer falls to the pull-down level
    assign drive = pin_out & pin_tmr_en;
    assign pin_level = drive;

    // Count source edge every eight cycles, synchronous to clk
    always_ff @(posedge clk)
    begin
        div_q <= div_q + 3'h1;
    end
    assign ext_clk = div_q[2];
endmodule
